// ===== verilog/uac_top.sv
// UART configuration and control block with APB registers and an interrupt for receive and transmit events.
// Assumes APB master on pclk; gpio_in and pins synchronous to pclk.
//
// Contract
// - UART enable gates interrupt, separate from global.
// - Five-bit transmit byte count, four plus one.
// - Control switches on UART oscillator clock.
// - Source bit picks 4 MHz or 3.6864 MHz.
// - Codes 0 to 10 pick 300 to 115200; 4 MHz source gives 125000 at code 10.
// - Writing one acknowledges and clears receive flag.
// - Mode 1 multiprocessor: ninth bit zero, no flag.
// - Mode 0 multiprocessor: stop zero, no flag.
// - Stop detection requires valid stop for flag.
// - Disable bit suppresses receive interrupt.
// - Mode selects eight bits, or with parity.
// - Parity select zero even, one odd.
// - Two-bit select picks receive pin two..five.
// - Start control sends programmed byte count.
`timescale 1ns/10ps
module uac_top
    import uac_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial pins: gpio_in[0..3] are pins 2..5
    input wire logic [3:0] gpio_in,
    output logic txd,
    // Interrupt to the processor
    output logic irq
);
    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;
        logic [7:0] txdat;
        logic [8:0] rxdat;
        logic [ST_W-1:0] stat;
        logic [ST_W-1:0] mask;
        logic [31:0] prdata;
        uac_rx_e rx_st;
        logic [3:0] rx_ph;
        logic [3:0] rx_bit;
        logic [8:0] rx_sh;
        uac_tx_e tx_st;
        logic [3:0] tx_ph;
        logic [3:0] tx_bit;
        logic [8:0] tx_sh;
        logic [4:0] tx_left;
        logic txo;
    } uac_state_s;

    uac_state_s s_r;
    uac_state_s s_nxt;
    uac_baud_if bif();

    logic wr;
    logic rd_setup;
    logic hit;
    logic tick;
    logic rx_pin;
    logic rx_ok;
    logic rx_set;
    logic tx_go;
    logic [ST_W-1:0] ev;
    logic [ST_W-1:0] irq_allow;
    logic [3:0] last_bit;
    logic [4:0] tx_cnt;

    uac_baud u_baud (
        .pclk(pclk),
        .presetn(presetn),
        .bif(bif)
    );

    assign bif.osc_en = s_r.ctrl[C_OSC_EN];
    assign bif.fast_src = s_r.ctrl[C_SRC];
    assign bif.code = s_r.ctrl[C_BAUD +: 4];
    assign tick = bif.tick16;

    // Zero wait states: read data is captured in the setup cycle
    assign pready = 1'b1;
    assign hit = (paddr == ADDR_CTRL) || (paddr == ADDR_TXCTL) || (paddr == ADDR_TXDATA)
        || (paddr == ADDR_RXDATA) || (paddr == ADDR_STATUS) || (paddr == ADDR_MASK);
    assign pslverr = psel && penable && !hit;
    assign wr = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign prdata = s_r.prdata;
    assign txd = s_r.txo;

    assign rx_pin = gpio_in[s_r.ctrl[C_RXSEL +: 2]];
    assign last_bit = s_r.ctrl[C_MODE] ? 4'h8 : 4'h7;
    assign tx_cnt = {s_r.ctrl[C_CNT_HI], s_r.ctrl[C_CNT_LO +: 4]};
    assign tx_go = wr && (paddr == ADDR_TXCTL) && pwdata[TX_GO] && (s_r.tx_st == TX_IDLE);

    // Flag qualification at the stop-bit sample
    always_comb
    begin
        rx_ok = 1'b1;
        if (s_r.ctrl[C_STOPDET] && !rx_pin)
        begin
            rx_ok = 1'b0;
        end
        if (s_r.ctrl[C_MPCOMM] && s_r.ctrl[C_MODE] && !s_r.rx_sh[8])
        begin
            rx_ok = 1'b0;
        end
        if (s_r.ctrl[C_MPCOMM] && !s_r.ctrl[C_MODE] && !rx_pin)
        begin
            rx_ok = 1'b0;
        end
    end

    assign rx_set = tick && (s_r.rx_st == RX_STOP) && (s_r.rx_ph == 4'hf) && rx_ok
        && s_r.ctrl[C_RX_EN];

    // Receive event reaches irq only while the UART enable is on and not disabled
    assign irq_allow = {2'b11, !s_r.ctrl[C_RXIRQ_DIS]};
    assign irq = s_r.ctrl[C_IRQ_EN] && |(s_r.stat & s_r.mask & irq_allow);

    always_comb
    begin
        s_nxt = s_r;
        ev = '0;
        ev[ST_RX] = rx_set;
        if (rd_setup)
        begin
            case (paddr)
                ADDR_CTRL: s_nxt.prdata = {12'h000, s_r.ctrl};
                ADDR_TXCTL: s_nxt.prdata = {31'h0, s_r.tx_st != TX_IDLE};
                ADDR_TXDATA: s_nxt.prdata = {24'h000000, s_r.txdat};
                ADDR_RXDATA: s_nxt.prdata = {23'h000000, s_r.rxdat};
                ADDR_STATUS: s_nxt.prdata = {29'h0, s_r.stat};
                ADDR_MASK: s_nxt.prdata = {29'h0, s_r.mask};
                default: s_nxt.prdata = 32'h00000000;
            endcase
        end
        if (wr)
        begin
            case (paddr)
                ADDR_CTRL: s_nxt.ctrl = pwdata[CTRL_W-1:0];
                ADDR_TXDATA: s_nxt.txdat = pwdata[7:0];
                ADDR_MASK: s_nxt.mask = pwdata[ST_W-1:0];
                default: s_nxt.ctrl = s_r.ctrl;
            endcase
        end

        // Receiver, sampling mid-bit at 16x
        case (s_r.rx_st)
            RX_IDLE:
            begin
                if (tick && !rx_pin && s_r.ctrl[C_RX_EN])
                begin
                    s_nxt.rx_st = RX_START;
                    s_nxt.rx_ph = 4'h0;
                end
            end
            RX_START:
            begin
                if (tick)
                begin
                    s_nxt.rx_ph = s_r.rx_ph + 4'h1;
                    if (s_r.rx_ph == 4'h7)
                    begin
                        // A glitch shorter than half a bit is not a start
                        s_nxt.rx_st = rx_pin ? RX_IDLE : RX_DATA;
                        s_nxt.rx_ph = 4'h0;
                        s_nxt.rx_bit = 4'h0;
                        s_nxt.rx_sh = '0;
                    end
                end
            end
            RX_DATA:
            begin
                if (tick)
                begin
                    s_nxt.rx_ph = s_r.rx_ph + 4'h1;
                    if (s_r.rx_ph == 4'hf)
                    begin
                        s_nxt.rx_sh[s_r.rx_bit] = rx_pin;
                        s_nxt.rx_bit = s_r.rx_bit + 4'h1;
                        if (s_r.rx_bit == last_bit)
                        begin
                            s_nxt.rx_st = RX_STOP;
                        end
                    end
                end
            end
            RX_STOP:
            begin
                if (tick)
                begin
                    s_nxt.rx_ph = s_r.rx_ph + 4'h1;
                    if (s_r.rx_ph == 4'hf)
                    begin
                        s_nxt.rx_st = RX_IDLE;
                        if (rx_ok)
                        begin
                            s_nxt.rxdat = s_r.rx_sh;
                        end
                    end
                end
            end
            default: s_nxt.rx_st = RX_IDLE;
        endcase
        if (!s_r.ctrl[C_RX_EN])
        begin
            s_nxt.rx_st = RX_IDLE;
        end

        // Transmitter; the holding register is reloaded per byte, so software
        // must refill it after each load event to send different bytes
        case (s_r.tx_st)
            TX_IDLE:
            begin
                if (tx_go && tx_cnt != 5'h00)
                begin
                    s_nxt.tx_left = tx_cnt;
                    s_nxt.tx_st = TX_START;
                    s_nxt.tx_ph = 4'h0;
                    s_nxt.tx_sh = {^s_r.txdat ^ s_r.ctrl[C_PAR], s_r.txdat};
                    ev[ST_TXLOAD] = 1'b1;
                end
            end
            TX_START:
            begin
                if (tick)
                begin
                    s_nxt.tx_ph = s_r.tx_ph + 4'h1;
                    if (s_r.tx_ph == 4'hf)
                    begin
                        s_nxt.tx_st = TX_DATA;
                        s_nxt.tx_bit = 4'h0;
                    end
                end
            end
            TX_DATA:
            begin
                if (tick)
                begin
                    s_nxt.tx_ph = s_r.tx_ph + 4'h1;
                    if (s_r.tx_ph == 4'hf)
                    begin
                        s_nxt.tx_bit = s_r.tx_bit + 4'h1;
                        if (s_r.tx_bit == last_bit)
                        begin
                            s_nxt.tx_st = TX_STOP;
                        end
                    end
                end
            end
            TX_STOP:
            begin
                if (tick)
                begin
                    s_nxt.tx_ph = s_r.tx_ph + 4'h1;
                    if (s_r.tx_ph == 4'hf)
                    begin
                        s_nxt.tx_left = s_r.tx_left - 5'h01;
                        if (s_r.tx_left == 5'h01)
                        begin
                            s_nxt.tx_st = TX_IDLE;
                            ev[ST_TXDONE] = 1'b1;
                        end
                        else
                        begin
                            s_nxt.tx_st = TX_START;
                            s_nxt.tx_sh = {^s_r.txdat ^ s_r.ctrl[C_PAR], s_r.txdat};
                            ev[ST_TXLOAD] = 1'b1;
                        end
                    end
                end
            end
            default: s_nxt.tx_st = TX_IDLE;
        endcase
        case (s_nxt.tx_st)
            TX_START: s_nxt.txo = 1'b0;
            TX_DATA: s_nxt.txo = s_nxt.tx_sh[s_nxt.tx_bit];
            default: s_nxt.txo = 1'b1;
        endcase

        // Write-one-to-clear; a new event in the same cycle wins
        if (wr && paddr == ADDR_STATUS)
        begin
            s_nxt.stat = s_r.stat & ~pwdata[ST_W-1:0];
        end
        s_nxt.stat = s_nxt.stat | ev;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_r <= '0;
            s_r.ctrl <= CTRL_RST;
            s_r.mask <= MASK_RST;
            s_r.txo <= 1'b1;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_irq_enable: assert property (irq |-> s_r.ctrl[C_IRQ_EN])
        else $error("Interrupt raised while UART interrupt enable is off");
    a_count_load: assert property (tx_go && tx_cnt != 5'h00 |=> s_r.tx_left == $past(tx_cnt))
        else $error("Byte count not loaded at start");
    a_ack_clear: assert property (wr && paddr == ADDR_STATUS && pwdata[ST_RX] && !rx_set
        |=> !s_r.stat[ST_RX])
        else $error("Receive flag not cleared by acknowledge");
    a_mp_ninth: assert property (rx_set && s_r.ctrl[C_MPCOMM] && s_r.ctrl[C_MODE]
        |-> s_r.rx_sh[8])
        else $error("Flag raised with ninth bit zero");
    a_mp_stop: assert property (rx_set && s_r.ctrl[C_MPCOMM] && !s_r.ctrl[C_MODE]
        |-> rx_pin ##1 s_r.stat[ST_RX])
        else $error("Flag raised with stop bit zero");
    a_stop_valid: assert property (rx_set && s_r.ctrl[C_STOPDET] |-> rx_pin)
        else $error("Flag raised without valid stop bit");
    a_rx_disable: assert property (s_r.ctrl[C_RXIRQ_DIS] && (s_r.stat & s_r.mask) == 3'h1
        |-> !irq)
        else $error("Receive interrupt while disabled");
    a_bit_limit: assert property (s_r.tx_st == TX_DATA |-> s_r.tx_bit <= last_bit)
        else $error("Too many data bits sent");
    a_parity_bit: assert property (s_r.tx_st == TX_DATA && s_r.tx_bit == 4'h8
        |-> txd == (^s_r.tx_sh[7:0] ^ s_r.ctrl[C_PAR]))
        else $error("Wrong parity bit");
    a_start_low: assert property (tx_go && tx_cnt != 5'h00 |=> !txd && s_r.tx_st == TX_START)
        else $error("Transmission did not start");
    a_stop_high: assert property (s_r.tx_st == TX_STOP || s_r.tx_st == TX_IDLE |-> txd)
        else $error("Line not high in stop or idle");
    a_rx_gated: assert property (!s_r.ctrl[C_RX_EN] |=> s_r.rx_st == RX_IDLE)
        else $error("Receiver active while disabled");

    c_rx_byte: cover property (rx_set);
    c_tx_multi: cover property (ev[ST_TXDONE] && tx_cnt > 5'h01);
    c_irq: cover property ($rose(irq));
    c_rx_reject: cover property (tick && s_r.rx_st == RX_STOP && s_r.rx_ph == 4'hf && !rx_ok);
endmodule : uac_top

// ===== verilog/uac_pkg.sv
// Shared constants, register map, field layout and state types of the UART block.
// Assumes a 100 MHz pclk and APB register access with 32-bit data.
package uac_pkg;
    // Clock and oscillator rates, in Hz
    localparam int unsigned PCLK_HZ = 100_000_000;
    localparam int unsigned OSC_FAST_HZ = 4_000_000;
    localparam int unsigned OSC_SLOW_HZ = 3_686_400;
    localparam int unsigned OVS = 16;
    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_TXCTL = 8'h04;
    localparam logic [7:0] ADDR_TXDATA = 8'h08;
    localparam logic [7:0] ADDR_RXDATA = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_MASK = 8'h14;
    // Control register fields
    localparam int CTRL_W = 20;
    localparam int C_IRQ_EN = 0;
    localparam int C_OSC_EN = 1;
    localparam int C_SRC = 2;
    localparam int C_MPCOMM = 3;
    localparam int C_STOPDET = 4;
    localparam int C_RXIRQ_DIS = 5;
    localparam int C_MODE = 6;
    localparam int C_RX_EN = 7;
    localparam int C_PAR = 8;
    localparam int C_RXSEL = 9;
    localparam int C_BAUD = 11;
    localparam int C_CNT_LO = 15;
    localparam int C_CNT_HI = 19;
    localparam logic [CTRL_W-1:0] CTRL_RST = 20'h00000;
    // Status and mask bits
    localparam int ST_W = 3;
    localparam int ST_RX = 0;
    localparam int ST_TXLOAD = 1;
    localparam int ST_TXDONE = 2;
    localparam logic [ST_W-1:0] MASK_RST = 3'h0;
    localparam int TX_GO = 0;

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} uac_rx_e;
    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} uac_tx_e;

    // Oscillator cycles per 1/16 bit; codes above 10 run at the top rate
    function automatic logic [9:0] uac_divisor(input logic [3:0] code, input logic fast);
        logic [9:0] d;
        d = 10'h002;
        case (code)
            4'h0: d = fast ? 10'h341 : 10'h300;
            4'h1: d = fast ? 10'h1a0 : 10'h180;
            4'h2: d = fast ? 10'h0d0 : 10'h0c0;
            4'h3: d = fast ? 10'h068 : 10'h060;
            4'h4: d = fast ? 10'h034 : 10'h030;
            4'h5: d = fast ? 10'h01a : 10'h018;
            4'h6: d = fast ? 10'h00d : 10'h00c;
            4'h7: d = 10'h006;
            4'h8: d = 10'h004;
            4'h9: d = 10'h003;
            default: d = 10'h002;
        endcase
        return d;
    endfunction : uac_divisor
endpackage : uac_pkg

// ===== verilog/uac_baud_if.sv
// Link between the UART core and its baud-rate generator.
// Assumes both ends run on pclk.
`timescale 1ns/10ps
interface uac_baud_if;
    logic osc_en;
    logic fast_src;
    logic [3:0] code;
    logic tick16;
    modport gen (input osc_en, input fast_src, input code, output tick16);
    modport user (output osc_en, output fast_src, output code, input tick16);
endinterface : uac_baud_if

// ===== verilog/uac_baud.sv
// Baud generator: emulates the selected oscillator from pclk, divides to 16x bit rate.
// Assumes pclk at PCLK_HZ; tick16 is a one-cycle enable pulse.
`timescale 1ns/10ps
module uac_baud
    import uac_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Core side
    uac_baud_if.gen bif
);
    typedef struct packed {
        logic [26:0] acc;
        logic [9:0] cnt;
        logic tick;
    } uac_bstate_s;

    uac_bstate_s s_r;
    uac_bstate_s s_nxt;
    logic [26:0] sum;
    logic [9:0] div;

    assign bif.tick16 = s_r.tick;

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        div = uac_divisor(bif.code, bif.fast_src);
        // Phase accumulator stands in for the oscillator edge
        sum = s_r.acc + (bif.fast_src ? 27'(OSC_FAST_HZ) : 27'(OSC_SLOW_HZ));
        if (!bif.osc_en)
        begin
            s_nxt.acc = '0;
            s_nxt.cnt = '0;
        end
        else if (sum >= 27'(PCLK_HZ))
        begin
            s_nxt.acc = sum - 27'(PCLK_HZ);
            if (s_r.cnt >= div - 10'h001)
            begin
                s_nxt.cnt = '0;
                s_nxt.tick = 1'b1;
            end
            else
            begin
                s_nxt.cnt = s_r.cnt + 10'h001;
            end
        end
        else
        begin
            s_nxt.acc = sum;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_div_bound: assert property (bif.osc_en |-> s_r.cnt <= 10'h340)
        else $error("Baud divider count out of range");
    a_osc_gate: assert property (!bif.osc_en |=> !s_r.tick && s_r.acc == '0)
        else $error("Baud tick while oscillator is off");
endmodule : uac_baud

// ===== verif/uac_partner.sv
// Serial partner model: drives the receive line, decodes frames seen on txd.
// Assumes the bench sets bit_ns and par_en before each transfer.
`timescale 1ns/10ps
module uac_partner
(
    // Serial lines
    input wire logic txd,
    output logic rxd
);
    real bit_ns = 8000.0;
    logic par_en = 1'b0;
    logic [9:0] got[$];

    initial rxd = 1'b1;

    // A trailing idle bit lets the receiver see the next falling edge after a low stop
    task automatic send(input logic [7:0] d, input logic nine_en, input logic ninth,
                        input logic stop);
        rxd = 1'b0;
        #(bit_ns);
        for (int i = 0; i < 8; i++)
        begin
            rxd = d[i];
            #(bit_ns);
        end
        if (nine_en)
        begin
            rxd = ninth;
            #(bit_ns);
        end
        rxd = stop;
        #(bit_ns);
        rxd = 1'b1;
        #(bit_ns);
    endtask : send

    // Mid-bit sampling; each entry is {stop, parity, data}
    always
    begin : rx_frame
        logic [9:0] f;
        @(negedge txd);
        f = 10'h000;
        #(bit_ns / 2.0);
        if (txd === 1'b0)
        begin
            for (int i = 0; i < 10; i++)
            begin
                if (i != 8 || par_en)
                begin
                    #(bit_ns);
                    f[i] = txd;
                end
            end
            got.push_back(f);
        end
    end
endmodule : uac_partner

// ===== verif/tb_uart_config_and_control.sv
// Self-checking bench: APB master, receive and transmit traffic through the partner.
// Assumes zero-wait APB answers and a 100 MHz pclk; baud code 10 keeps frames short.
`timescale 1ns/10ps
module tb_uart_config_and_control;
    import uac_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] gpio_in = 4'h1;
    logic txd;
    logic irq;
    logic rxd;
    logic [1:0] sel = 2'h0;
    int n_mismatch = 0;
    int checks = 0;
    logic [31:0] seed = 32'h5bf7;
    logic [31:0] rd;
    logic err;
    logic [31:0] ctrl_m;
    // First entry: low stop with detection off must still raise the flag
    logic [7:0] rc[6] = '{8'h04, 8'hcc, 8'h54, 8'hb6, 8'hb7, 8'h42};
    logic [4:0] tc[3] = '{5'h02, 5'h01, 5'h01};
    logic [2:0] ts = 3'b101;
    logic [2:0] tm = 3'b110;
    logic [2:0] tp = 3'b100;

    always #5 pclk = ~pclk;
    // Unselected pins carry the inverse, so a wrong pick shows as garbage
    always @(posedge pclk) gpio_in <= ~({4{rxd}} ^ (4'h1 << sel));

    uac_top i_uac_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .gpio_in(gpio_in), .txd(txd), .irq(irq));
    uac_partner i_uac_partner (.txd(txd), .rxd(rxd));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    function automatic logic [31:0] cfg(input logic src, input logic mode, input logic par,
        input logic mp, input logic sd, input logic rxen, input logic [1:0] s,
        input logic [4:0] cnt);
        logic [31:0] c;
        c = 32'h0;
        c[C_IRQ_EN] = 1'b1;
        c[C_OSC_EN] = 1'b1;
        c[C_SRC] = src;
        c[C_MPCOMM] = mp;
        c[C_STOPDET] = sd;
        c[C_MODE] = mode;
        c[C_RX_EN] = rxen;
        c[C_PAR] = par;
        c[C_RXSEL +: 2] = s;
        c[C_BAUD +: 4] = 4'ha;
        c[C_CNT_LO +: 4] = cnt[3:0];
        c[C_CNT_HI] = cnt[4];
        return c;
    endfunction : cfg

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        apb(1'b1, a, v);
    endtask : wr

    task automatic wr_ctrl(input logic [31:0] v);
        ctrl_m = v;
        apb(1'b1, ADDR_CTRL, v);
    endtask : wr_ctrl

    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                       input string what);
        apb(1'b0, a, 32'h0);
        check(what, rd & m, e);
    endtask : rdc

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    initial
    begin : main
        logic [7:0] d;
        logic [7:0] c;
        logic [9:0] f;
        logic fl;
        int n;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rdc(ADDR_CTRL, 32'hffffffff, {12'h0, CTRL_RST}, "ctrl reset");
        rdc(ADDR_MASK, 32'hffffffff, {29'h0, MASK_RST}, "mask reset");
        check("mapped slverr", err, 1'b0);
        rdc(ADDR_STATUS, 32'hffffffff, 32'h0, "status reset");
        check("txd idle", txd, 1'b1);
        check("irq reset", irq, 1'b0);
        apb(1'b0, 8'h18, 32'h0);
        check("hole", rd, 32'h0);
        check("hole slverr", err, 1'b1);
        wr(ADDR_RXDATA, 32'h1ff);
        rdc(ADDR_RXDATA, 32'h1ff, 32'h0, "rxdata ro");
        seed = lfsr(seed);
        wr(ADDR_CTRL, {12'h0, seed[19:0]});
        rdc(ADDR_CTRL, 32'hffffffff, {12'h0, seed[19:0]}, "ctrl rw");
        wr_ctrl(cfg(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 5'h00));
        wr(ADDR_TXCTL, 32'h1);
        rdc(ADDR_TXCTL, 32'h1, 32'h0, "count zero");
        // Only the transfer-done event may reach irq during the transmit runs
        wr(ADDR_MASK, 32'h4);
        for (int t = 0; t < 3; t++)
        begin
            seed = lfsr(seed);
            d = seed[7:0];
            i_uac_partner.par_en = tm[t];
            i_uac_partner.bit_ns = ts[t] ? 8000.0 : 1.0e9 * 32.0 / 3686400.0;
            wr(ADDR_TXDATA, {24'h0, d});
            wr_ctrl(cfg(ts[t], tm[t], tp[t], 1'b0, 1'b0, 1'b0, 2'h0, tc[t]));
            wr(ADDR_STATUS, 32'h7);
            wr(ADDR_TXCTL, 32'h1);
            rdc(ADDR_TXCTL, 32'h1, 32'h1, "tx busy");
            n = 0;
            rd = 32'h0;
            while (rd[ST_TXDONE] !== 1'b1 && n < 30000)
            begin
                apb(1'b0, ADDR_STATUS, 32'h0);
                n++;
            end
            check("tx done", rd[ST_TXDONE], 1'b1);
            check("tx load", rd[ST_TXLOAD], 1'b1);
            check("irq done", irq, 1'b1);
            check("tx frames", i_uac_partner.got.size(), tc[t]);
            while (i_uac_partner.got.size() > 0)
            begin
                f = i_uac_partner.got.pop_front();
                check("tx frame", f, {1'b1, tm[t] & (^d ^ tp[t]), d});
            end
        end
        i_uac_partner.bit_ns = 8000.0;
        foreach (rc[k])
        begin
            c = rc[k];
            seed = lfsr(seed);
            d = seed[7:0];
            wr(ADDR_CTRL, 32'h0);
            sel <= c[7:6];
            wr_ctrl(cfg(1'b1, c[5], 1'b0, c[4], c[3], c[2], c[7:6], 5'h00));
            wr(ADDR_STATUS, 32'h7);
            wr(ADDR_MASK, 32'h1);
            i_uac_partner.send(d, c[5], c[0], c[1]);
            fl = c[2] & ~(c[3] & ~c[1]) & ~(c[4] & ~c[5] & ~c[1]) & ~(c[4] & c[5] & ~c[0]);
            rdc(ADDR_STATUS, 32'h1, {31'h0, fl}, "rx flag");
            check("irq", irq, fl);
            if (fl)
            begin
                rdc(ADDR_RXDATA, c[5] ? 32'h1ff : 32'hff, {23'h0, c[0], d}, "rx data");
                wr_ctrl(ctrl_m | (32'h1 << C_RXIRQ_DIS));
                check("irq off", irq, 1'b0);
                wr_ctrl(ctrl_m & ~((32'h1 << C_IRQ_EN) | (32'h1 << C_RXIRQ_DIS)));
                check("irq gate", irq, 1'b0);
                wr(ADDR_STATUS, 32'h1);
                rdc(ADDR_STATUS, 32'h1, 32'h0, "rx ack");
            end
        end
        end_sim();
    end

    initial
    begin : watchdog
        #1000000;
        n_mismatch++;
        $display("watchdog expired");
        end_sim();
    end
endmodule : tb_uart_config_and_control
